// File: core/xlat_pkg.sv
// shared constants and carrier types for the page translator
package xlat_pkg;
   // control word bit positions
   localparam int PG_BIT   = 31;
   localparam int WIDE_BIT = 5;
   localparam int BIG_BIT  = 4;
   // entry bit positions
   localparam int PRES_BIT = 0;
   localparam int LPS_BIT  = 7;
   // feature query
   localparam logic [31:0] FEAT_LEAF = 32'h0000_0001;
   localparam int          FEAT_BIT  = 17;
   // address widths
   localparam int LIN_W = 48;
   localparam int PA_W  = 40;
   localparam int LEG_W = 32;
   localparam int XL_W  = 36;
   // table levels
   localparam logic [1:0] LV_TOP = 2'h3;
   localparam logic [1:0] LV_PTR = 2'h2;
   localparam logic [1:0] LV_DIR = 2'h1;
   localparam logic [1:0] LV_LEAF = 2'h0;

   typedef struct packed {
      logic [31:0] cw0;
      logic [31:0] cw4;
      logic        lm_req;
   } ctl_t;

   typedef struct packed {
      logic            valid;
      logic [PA_W-1:0] addr;
      logic            wide;
   } mrd_t;

   typedef struct packed {
      logic            done;
      logic [PA_W-1:0] phys;
      logic            pf;
      logic            gp;
   } res_t;

   typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT} fsm_t;
endpackage

// File: core/rsv_check.sv
// reserved bit checker for one fetched table entry
`timescale 1ns/1ns
module rsv_check (
   input  wire logic [63:0] entry,
   input  wire logic [1:0]  lvl,
   input  wire logic        lm,
   input  wire logic        wide,
   input  wire logic        big,
   output logic             bad
);
   import xlat_pkg::*;
   logic ps;
   always_comb begin
      ps  = entry[LPS_BIT];
      bad = 1'b0;
      if (!(wide || big)) begin
         bad = 1'b0;
      end else if (lm) begin
         bad = entry[63] || (|entry[51:40]);
         if (lvl == LV_DIR && ps) begin
            bad = bad || (|entry[20:13]);
         end
      end else if (wide) begin
         bad = |entry[63:40];
         if (lvl == LV_PTR) begin
            bad = bad || (|entry[8:5]) || (|entry[2:1]);
         end else if (lvl == LV_DIR && ps) begin
            bad = bad || (|entry[20:13]);
         end
      end else begin
         bad = (lvl == LV_DIR) && ps && entry[21];
      end
   end
endmodule // rsv_check

// File: core/page_xlat.sv
// linear to physical page translation walker
`timescale 1ns/1ns
module page_xlat (
   input  wire logic                     clk,
   input  wire logic                     rstn,
   input  wire xlat_pkg::ctl_t           ctl,
   input  wire logic                     req_valid,
   input  wire logic [xlat_pkg::LIN_W-1:0] req_lin,
   input  wire logic [xlat_pkg::PA_W-1:0]  root_base,
   output logic                          req_ready,
   output xlat_pkg::mrd_t                mrd,
   input  wire logic                     mem_rsp_valid,
   input  wire logic [63:0]              mem_rsp_data,
   output xlat_pkg::res_t                res,
   output logic                          lm_active,
   input  wire logic                     feat_req,
   input  wire logic [31:0]              feat_leaf,
   output logic                          feat_valid,
   output logic [31:0]                   feat_result
);
   import xlat_pkg::*;

   typedef struct packed {
      fsm_t            fsm;
      logic [1:0]      lvl;
      logic [LIN_W-1:0] lin;
      logic [PA_W-1:0] base;
      logic            lm;
      logic            lm_req_d;
      logic            ready;
      mrd_t            mrd;
      res_t            res;
      logic            fv;
      logic [31:0]     fr;
   } st_t;

   st_t st_r;
   st_t st_nxt;

   logic        pg_on;
   logic        wide;
   logic        big;
   logic [63:0] ent;
   logic        bad;
   logic        ps;
   logic [PA_W-1:0] ent_addr;

   ////////////////////////////////////////////////////////////////////
   // control decode and entry view
   always_comb begin
      pg_on = ctl.cw0[PG_BIT];
      wide  = ctl.cw4[WIDE_BIT];
      big   = ctl.cw4[BIG_BIT];
      // narrow entries occupy the low word only
      ent   = (wide || st_r.lm) ? mem_rsp_data
                                : {32'h0000_0000, mem_rsp_data[31:0]};
      ps    = ent[LPS_BIT];
   end

   rsv_check u_rsv (
      .entry (ent),
      .lvl   (st_r.lvl),
      .lm    (st_r.lm),
      .wide  (wide),
      .big   (big),
      .bad   (bad)
   );

   ////////////////////////////////////////////////////////////////////
   // address of the entry for the current level
   always_comb begin
      ent_addr = '0;
      if (st_r.lm) begin
         // nine index bits per level, eight-byte entries
         case (st_r.lvl)
            LV_TOP:  ent_addr = {st_r.base[PA_W-1:12], st_r.lin[47:39], 3'h0};
            LV_PTR:  ent_addr = {st_r.base[PA_W-1:12], st_r.lin[38:30], 3'h0};
            LV_DIR:  ent_addr = {st_r.base[PA_W-1:12], st_r.lin[29:21], 3'h0};
            default: ent_addr = {st_r.base[PA_W-1:12], st_r.lin[20:12], 3'h0};
         endcase
      end else if (wide) begin
         case (st_r.lvl)
            LV_PTR:  ent_addr = {st_r.base[PA_W-1:5], st_r.lin[31:30], 3'h0};
            LV_DIR:  ent_addr = {st_r.base[PA_W-1:12], st_r.lin[29:21], 3'h0};
            default: ent_addr = {st_r.base[PA_W-1:12], st_r.lin[20:12], 3'h0};
         endcase
      end else begin
         case (st_r.lvl)
            LV_DIR:  ent_addr = {st_r.base[PA_W-1:12], st_r.lin[31:22], 2'h0};
            default: ent_addr = {st_r.base[PA_W-1:12], st_r.lin[21:12], 2'h0};
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      st_nxt           = st_r;
      st_nxt.mrd.valid = 1'b0;
      st_nxt.res.done  = 1'b0;
      st_nxt.res.pf    = 1'b0;
      st_nxt.res.gp    = 1'b0;
      st_nxt.fv        = 1'b0;
      st_nxt.lm_req_d  = ctl.lm_req;

      // feature query answer
      if (feat_req) begin
         st_nxt.fv = 1'b1;
         st_nxt.fr = '0;
         if (feat_leaf == FEAT_LEAF) begin
            st_nxt.fr[FEAT_BIT] = 1'b1;
         end
      end

      // long mode activation
      if (ctl.lm_req && !st_r.lm_req_d) begin
         if (!wide) begin
            st_nxt.res.gp = 1'b1;
         end else begin
            st_nxt.lm = 1'b1;
         end
      end else if (!ctl.lm_req) begin
         st_nxt.lm = 1'b0;
      end

      case (st_r.fsm)
         S_IDLE: begin
            if (req_valid && st_r.ready) begin
               st_nxt.lin  = req_lin;
               st_nxt.base = root_base;
               if (!pg_on) begin
                  // paging off: physical is the low 32 linear bits, zero extended
                  st_nxt.res.done = 1'b1;
                  st_nxt.res.phys = {8'h00, req_lin[LEG_W-1:0]};
               end else begin
                  st_nxt.ready = 1'b0;
                  st_nxt.fsm   = S_ISSUE;
                  if (st_r.lm) begin
                     st_nxt.lvl = LV_TOP;
                  end else if (wide) begin
                     st_nxt.lvl = LV_PTR;
                  end else begin
                     st_nxt.lvl = LV_DIR;
                  end
               end
            end
         end
         S_ISSUE: begin
            st_nxt.mrd.valid = 1'b1;
            st_nxt.mrd.addr  = ent_addr;
            st_nxt.mrd.wide  = wide || st_r.lm;
            st_nxt.fsm       = S_WAIT;
         end
         S_WAIT: begin
            if (mem_rsp_valid) begin
               st_nxt.fsm = S_ISSUE;
               if (!ent[PRES_BIT]) begin
                  st_nxt.res.pf = 1'b1;
                  st_nxt.res.done = 1'b1;
               end else if (bad && st_r.lvl == LV_PTR) begin
                  st_nxt.res.gp = 1'b1;
                  st_nxt.res.done = 1'b1;
               end else if (bad) begin
                  st_nxt.res.pf = 1'b1;
                  st_nxt.res.done = 1'b1;
               end else if (st_r.lm || wide) begin
                  case (st_r.lvl)
                     LV_TOP: begin
                        st_nxt.base = {ent[39:12], 12'h000};
                        st_nxt.lvl  = LV_PTR;
                     end
                     LV_PTR: begin
                        st_nxt.base = st_r.lm ? {ent[39:12], 12'h000}
                                              : {4'h0, ent[35:12], 12'h000};
                        st_nxt.lvl  = LV_DIR;
                     end
                     LV_DIR: begin
                        if (ps) begin
                           // 2-MByte page, big_page_ext not consulted
                           st_nxt.res.phys = {ent[39:21], st_r.lin[20:0]};
                           st_nxt.res.done = 1'b1;
                        end else begin
                           st_nxt.base = {ent[39:12], 12'h000};
                           st_nxt.lvl  = LV_LEAF;
                        end
                     end
                     default: begin
                        // upper 16 linear bits used only by the long mode top and pointer indexes
                        st_nxt.res.phys = {ent[39:12], st_r.lin[11:0]};
                        st_nxt.res.done = 1'b1;
                     end
                  endcase
               end else begin
                  if (st_r.lvl == LV_DIR && big && ps) begin
                     // 14 base bits: 35:32 from entry 16:13, 31:22 from entry
                     st_nxt.res.phys = {4'h0, ent[16:13], ent[31:22],
                                        st_r.lin[21:0]};
                     st_nxt.res.done = 1'b1;
                  end else if (st_r.lvl == LV_DIR) begin
                     st_nxt.base = {8'h00, ent[31:12], 12'h000};
                     st_nxt.lvl  = LV_LEAF;
                  end else begin
                     st_nxt.res.phys = {8'h00, ent[31:12], st_r.lin[11:0]};
                     st_nxt.res.done = 1'b1;
                  end
               end
               if (st_nxt.res.done) begin
                  st_nxt.fsm   = S_IDLE;
                  st_nxt.ready = 1'b1;
               end
            end
         end
         default: begin
            st_nxt.fsm   = S_IDLE;
            st_nxt.ready = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clk) begin
      if (!rstn) begin
         st_r       <= '0;
         st_r.ready <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_comb begin
      req_ready   = st_r.ready;
      mrd         = st_r.mrd;
      res         = st_r.res;
      lm_active   = st_r.lm;
      feat_valid  = st_r.fv;
      feat_result = st_r.fr;
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   logic acc;
   assign acc = req_valid && req_ready && st_r.fsm == S_IDLE;

   property p_no_paging;
      @(posedge clk) disable iff (!rstn)
      acc && !ctl.cw0[PG_BIT] |=> res.done && res.phys[31:0] == $past(req_lin[31:0]);
   endproperty
   a_no_paging: assert property (p_no_paging) else $error("paging off not bypassed");

   property p_lm_gp;
      @(posedge clk) disable iff (!rstn)
      ctl.lm_req && !$past(ctl.lm_req) && !ctl.cw4[WIDE_BIT] |=> res.gp && !lm_active;
   endproperty
   a_lm_gp: assert property (p_lm_gp) else $error("long mode without wide entries");

   property p_feat;
      @(posedge clk) disable iff (!rstn)
      feat_req && feat_leaf == FEAT_LEAF |=> feat_valid && feat_result[FEAT_BIT];
   endproperty
   a_feat: assert property (p_feat) else $error("feature bit missing");

   property p_one_fetch;
      @(posedge clk) disable iff (!rstn)
      mrd.valid |=> !mrd.valid;
   endproperty
   a_one_fetch: assert property (p_one_fetch) else $error("fetch held");

   property p_wide_rd;
      @(posedge clk) disable iff (!rstn)
      mrd.valid && (ctl.cw4[WIDE_BIT] || lm_active) |-> mrd.wide;
   endproperty
   a_wide_rd: assert property (p_wide_rd) else $error("narrow read of wide entry");

   property p_legacy_idx;
      @(posedge clk) disable iff (!rstn)
      acc && ctl.cw0[PG_BIT] && !ctl.cw4[WIDE_BIT] && !lm_active
      |=> ##1 mrd.valid && mrd.addr[11:2] == $past(req_lin[31:22], 2);
   endproperty
   a_legacy_idx: assert property (p_legacy_idx) else $error("bad directory index");

   property p_lm_idx;
      @(posedge clk) disable iff (!rstn)
      acc && ctl.cw0[PG_BIT] && lm_active
      |=> ##1 mrd.valid && mrd.addr[11:3] == $past(req_lin[47:39], 2);
   endproperty
   a_lm_idx: assert property (p_lm_idx) else $error("bad top index");

   property p_skip_top;
      @(posedge clk) disable iff (!rstn)
      acc && ctl.cw0[PG_BIT] && !lm_active |=> st_r.lvl != LV_TOP;
   endproperty
   a_skip_top: assert property (p_skip_top) else $error("top table walked");

   property p_done_pulse;
      @(posedge clk) disable iff (!rstn)
      res.done |=> !res.done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done held");

   c_big_page: cover property (@(posedge clk) disable iff (!rstn)
      res.done && !res.pf && res.phys[35:32] != 4'h0);
   c_lm_done: cover property (@(posedge clk) disable iff (!rstn)
      res.done && lm_active && !res.pf);
   c_pf: cover property (@(posedge clk) disable iff (!rstn) res.pf);
endmodule // page_xlat

// File: dv/mem_model.sv
// memory model that answers table entry reads for the walker
`timescale 1ns/1ns
module mem_model (
   input  wire logic           clk,
   input  wire logic           rstn,
   input  wire xlat_pkg::mrd_t mrd,
   input  wire logic [3:0]     lat,
   output logic                rsp_valid,
   output logic [63:0]         rsp_data
);
   import xlat_pkg::*;
   logic [63:0] mem [logic [39:0]];
   logic [63:0] last_r = 64'h0;
   logic [39:0] addr_r = 40'h0;
   logic        wide_r = 1'b0;
   logic [4:0]  cnt_r  = 5'h0;
   logic [63:0] d;

   ////////////////////////////////////////////////////////////////////////////
   // answer lat+1 cycles after a read; between answers the data lines show junk
   always @(posedge clk) begin
      rsp_valid <= 1'b0;
      rsp_data  <= ~last_r;
      if (!rstn) begin
         cnt_r <= 5'h0;
      end else if (mrd.valid) begin
         addr_r <= mrd.addr;
         wide_r <= mrd.wide;
         cnt_r  <= {1'b0, lat} + 5'h1;
      end else if (cnt_r == 5'h1) begin
         d = mem.exists(addr_r) ? mem[addr_r] : 64'h0;
         // a narrow read only owns the low word
         if (!wide_r) d[63:32] = ~d[31:0];
         rsp_valid <= 1'b1;
         rsp_data  <= d;
         last_r    <= d;
         cnt_r     <= 5'h0;
      end else if (cnt_r != 5'h0) begin
         cnt_r <= cnt_r - 5'h1;
      end
   end
endmodule // mem_model

// File: dv/testbench.sv
// self-checking bench for the page translation walker
`timescale 1ns/1ns
module testbench;
   import xlat_pkg::*;
   logic        clk       = 1'b0;
   logic        rstn      = 1'b0;
   ctl_t        ctl       = '0;
   logic        req_valid = 1'b0;
   logic [47:0] req_lin   = '0;
   logic [39:0] root_base = 40'h00_1234_5000;
   logic        feat_req  = 1'b0;
   logic [31:0] feat_leaf = '0;
   logic [3:0]  lat       = 4'h0;
   logic        req_ready;
   mrd_t        mrd;
   logic        rsp_valid;
   logic [63:0] rsp_data;
   res_t        res;
   res_t        r;
   logic        lm_active;
   logic        feat_valid;
   logic [31:0] feat_result;
   logic [39:0] exp_q[$];
   int          failures = 0;
   int          samples_checked = 0;
   int          cycles = 0;

   page_xlat page_xlat_i (.clk(clk), .rstn(rstn), .ctl(ctl), .req_valid(req_valid),
      .req_lin(req_lin), .root_base(root_base), .req_ready(req_ready), .mrd(mrd),
      .mem_rsp_valid(rsp_valid), .mem_rsp_data(rsp_data), .res(res), .lm_active(lm_active),
      .feat_req(feat_req), .feat_leaf(feat_leaf), .feat_valid(feat_valid),
      .feat_result(feat_result));
   mem_model mem_model_i (.clk(clk), .rstn(rstn), .mrd(mrd), .lat(lat),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data));

   always #20 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         stop_test();
      end
   end

   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one translation; every entry read is matched against exp_q in order
   task automatic xlat(input logic [47:0] lin, input logic wide);
      int n;
      req_lin   = lin;
      req_valid = 1'b1;
      @(negedge clk);
      req_valid = 1'b0;
      n = 0;
      while (res.done !== 1'b1 && n < 200) begin
         if (mrd.valid === 1'b1) begin
            chk("entry address", 64'(exp_q.pop_front()), 64'(mrd.addr));
            chk("entry width", 64'(wide), 64'(mrd.wide));
         end
         @(negedge clk);
         n++;
      end
      r = res;
      chk("done", 64'h1, 64'(res.done));
      chk("reads left", 64'h0, 64'(exp_q.size()));
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_off();
      xlat(48'h0000_89ab_cdef, 1'b0);
      chk("unpaged phys", 64'h00_89ab_cdef, 64'(r.phys));
      $display("test paging off done");
   endtask

   task automatic t_4m();
      logic [47:0] lin;
      logic [39:0] a;
      lin = 48'h0000_c012_3456;
      ctl.cw0 = 32'h8000_0000;
      ctl.cw4 = 32'h0000_0010;
      a = {root_base[39:12], lin[31:22], 2'b00};
      mem_model_i.mem[a] = {32'h0, 10'h2a0, 5'h0, 4'h5, 13'h0081};
      exp_q.push_back(a);
      xlat(lin, 1'b0);
      chk("4m phys", 64'({4'h0, 4'h5, 10'h2a0, lin[21:0]}), 64'(r.phys));
      chk("extra lines", 64'h5, 64'(r.phys[35:32]));
      $display("test large page done");
   endtask

   task automatic t_4k();
      logic [47:0] lin;
      logic [39:0] a;
      lin = 48'h0000_4076_5abc;
      lat = 4'h3;
      a = {root_base[39:12], lin[31:22], 2'b00};
      mem_model_i.mem[a] = {32'h0, 20'h0_abcd, 12'h001};
      exp_q.push_back(a);
      a = {8'h0, 20'h0_abcd, lin[21:12], 2'b00};
      mem_model_i.mem[a] = {32'h0, 20'h1_2345, 12'h001};
      exp_q.push_back(a);
      xlat(lin, 1'b0);
      chk("4k phys", 64'({8'h0, 20'h1_2345, lin[11:0]}), 64'(r.phys));
      lat = 4'h0;
      $display("test small page done");
   endtask

   task automatic t_lm();
      logic seen;
      seen = 1'b0;
      ctl.lm_req = 1'b1;
      repeat (4) begin
         @(negedge clk);
         if (res.gp === 1'b1) seen = 1'b1;
      end
      chk("activation fault", 64'h1, 64'(seen));
      chk("long mode refused", 64'h0, 64'(lm_active));
      ctl.lm_req = 1'b0;
      ctl.cw4    = 32'h0000_0030;
      @(negedge clk);
      ctl.lm_req = 1'b1;
      repeat (2) @(negedge clk);
      chk("long mode on", 64'h1, 64'(lm_active));
      $display("test long mode entry done");
   endtask

   task automatic t_feat();
      // strobe held high across the leaves, one query per clock
      feat_req = 1'b1;
      for (int l = 0; l < 3; l++) begin
         feat_leaf = 32'(l);
         @(negedge clk);
         chk("feature valid", 64'h1, 64'(feat_valid));
         chk("feature result", (l == 1) ? 64'h2_0000 : 64'h0, 64'(feat_result));
      end
      feat_req = 1'b0;
      $display("test feature query done");
   endtask

   // long walk; bad names the level whose entry has a reserved bit, 9 for none
   task automatic t_long(input logic big2m, input int bad);
      logic [47:0] lin;
      logic [39:0] a;
      logic [39:0] b;
      logic [63:0] e;
      int          n;
      lin = 48'ha5c3_9e17_2bcd;
      n = big2m ? 3 : 4;
      a = root_base;
      for (int k = 0; k < n; k++) begin
         b = {4'h9, 8'(k + 1), 28'h040_0000};
         a = {a[39:12], lin[47 - 9 * k -: 9], 3'b000};
         e = {24'h0, b[39:12], 12'h003};
         if (big2m && k == 2) e[7] = 1'b1;
         if (k == bad) e[45] = 1'b1;
         if (k <= bad) exp_q.push_back(a);
         mem_model_i.mem[a] = e;
         a = b;
      end
      xlat(lin, 1'b1);
      chk("page fault", 64'(bad < 9 && bad != 1), 64'(r.pf));
      chk("protection fault", 64'(bad == 1), 64'(r.gp));
      if (bad == 9 && big2m) begin
         chk("2m phys", 64'({a[39:21], lin[20:0]}), 64'(r.phys));
      end
      if (bad == 9 && !big2m) begin
         chk("4k long phys", 64'({a[39:12], lin[11:0]}), 64'(r.phys));
      end
      $display("test long walk done");
   endtask

   // wide entries outside long mode: pointer, directory and leaf, no top table
   task automatic t_pae();
      logic [47:0] lin;
      logic [39:0] a;
      lin = 48'h0000_9234_5678;
      ctl.lm_req = 1'b0;
      ctl.cw4    = 32'h0000_0020;
      @(negedge clk);
      chk("long mode off", 64'h0, 64'(lm_active));
      a = {root_base[39:5], lin[31:30], 3'b000};
      mem_model_i.mem[a] = {28'h000_0000, 24'h00_0456, 12'h001};
      exp_q.push_back(a);
      a = {4'h0, 24'h00_0456, lin[29:21], 3'b000};
      mem_model_i.mem[a] = {24'h00_0000, 28'h000_0789, 12'h001};
      exp_q.push_back(a);
      a = {28'h000_0789, lin[20:12], 3'b000};
      mem_model_i.mem[a] = {24'h00_0000, 28'h012_3456, 12'h001};
      exp_q.push_back(a);
      xlat(lin, 1'b1);
      chk("wide phys", 64'({28'h012_3456, lin[11:0]}), 64'(r.phys));
      chk("wide fault", 64'h0, 64'({r.pf, r.gp}));
      $display("test wide legacy walk done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(negedge clk);
      rstn = 1'b1;
      chk("ready after reset", 64'h1, 64'(req_ready));
      t_off();
      t_4m();
      t_4k();
      t_lm();
      t_feat();
      t_long(1'b0, 9);
      t_long(1'b1, 9);
      t_long(1'b0, 2);
      t_long(1'b0, 1);
      t_long(1'b1, 2);
      t_long(1'b0, 3);
      t_pae();
      stop_test();
   end
endmodule // testbench
